// file: core/ieq_pkg.sv
// constants, register map and state codes of the equalizer config port
// assumes a serial-bus master elsewhere on a shared two-wire bus
//
// Operation
// - power-on loads control bytes from straps
// - bus writes controls only in bus mode
// - a-side byte drives all four a channels
// - b-side byte drives all four b channels
// - b-side byte at offset nine, split 3/3/2
// - test byte ten resets to zero
// - test byte eleven resets to ef
// - eight bits then one acknowledge bit
// - most significant bit goes first
// - clock line is never driven
// - every transfer starts at offset zero
// - first written data byte is filler
// - address 11x00xx plus direction bit
// - byte after start compared with address
// - acknowledge held low through clock high
// - data falling while clock high starts
// - data rising while clock high stops
// - a-side byte at offset eight, split 3/3/2
package ieq_pkg;

	// register offsets (byte pointer values)
	localparam logic [3:0] OFS_A_SIDE_CTRL = 4'h8;
	localparam logic [3:0] OFS_B_SIDE_CTRL = 4'h9;
	localparam logic [3:0] OFS_MFG_TEST_A = 4'ha;
	localparam logic [3:0] OFS_MFG_TEST_B = 4'hb;

	// power-up values of the test bytes, and the unmapped read value
	localparam logic [7:0] MFG_TEST_A_RST = 8'h00;
	localparam logic [7:0] MFG_TEST_B_RST = 8'hef;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// field positions inside a control byte
	localparam int EQ_SEL_MSB = 7;
	localparam int EQ_SEL_LSB = 5;
	localparam int DEEMPH_MSB = 4;
	localparam int DEEMPH_LSB = 2;
	localparam int SWING_MSB = 1;
	localparam int SWING_LSB = 0;

	// fixed parts of the bus address
	localparam logic [1:0] ADDR_FIXED_HI = 2'h3;
	localparam logic [1:0] ADDR_FIXED_MID = 2'h0;

	// cycles after reset before the straps are taken
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
	localparam int CHANNELS_PER_SIDE = 4;

	typedef enum logic [2:0] {
		IEQ_IDLE = 3'b000,
		IEQ_ADDR = 3'b001,
		IEQ_ACK_TX = 3'b010,
		IEQ_WR_BYTE = 3'b011,
		IEQ_RD_BIT = 3'b100,
		IEQ_RD_ACK = 3'b101
	} ieq_state_t;

endpackage

// file: core/ieq_config_slave.sv
// two-wire serial slave with the equalizer and test control bytes
// assumes SCL_IN and SDA_IN come from open-drain bus wires, resolved outside
module ieq_config_slave (
	input wire logic CLK_IN, // 20 MHz system clock
	input wire logic RST_IN, // async reset, active high
	input wire logic SCL_IN, // bus clock, also the link clock
	input wire logic SDA_IN, // bus data level
	output logic SDA_OUT, // bus data drive value, always low
	output logic SDA_OE_OUT, // high while pulling data low
	input wire logic [2:0] A_SIDE_EQ_SELECT_IN, // a-side equalizer strap
	input wire logic [2:0] A_SIDE_DEEMPH_LEVEL_IN, // a-side de-emphasis strap
	input wire logic [1:0] A_SIDE_SWING_LEVEL_IN, // a-side swing strap
	input wire logic [2:0] B_SIDE_EQ_SELECT_IN, // b-side equalizer strap
	input wire logic [2:0] B_SIDE_DEEMPH_LEVEL_IN, // b-side de-emphasis strap
	input wire logic [1:0] B_SIDE_SWING_LEVEL_IN, // b-side swing strap
	input wire logic BUS_ADDR_STRAP_BIT0_IN, // address bit 0 strap
	input wire logic BUS_ADDR_STRAP_BIT1_IN, // address bit 1 strap
	input wire logic BUS_ADDR_STRAP_BIT4_IN, // address bit 4 strap
	input wire logic CFG_SRC_BUS_IN, // high selects bus configuration
	output logic [3:0][2:0] A_SIDE_EQ_SELECT_OUT, // per a channel
	output logic [3:0][2:0] A_SIDE_DEEMPH_LEVEL_OUT, // per a channel
	output logic [3:0][1:0] A_SIDE_SWING_LEVEL_OUT, // per a channel
	output logic [3:0][2:0] B_SIDE_EQ_SELECT_OUT, // per b channel
	output logic [3:0][2:0] B_SIDE_DEEMPH_LEVEL_OUT, // per b channel
	output logic [3:0][1:0] B_SIDE_SWING_LEVEL_OUT, // per b channel
	output logic [7:0] MFG_TEST_A_OUT, // test byte ten
	output logic [7:0] MFG_TEST_B_OUT, // test byte eleven
	output logic CFG_LOADED_OUT // straps have been taken
);

	////////////////////////////////////////////////////////////////////////
	// link domain: sample data on each rising bus clock edge

	typedef struct packed {
		logic bit_val;
		logic tog;
	} ieq_link_t;

	ieq_link_t link_reg;
	ieq_link_t link_next;

	// capture the bit and flag the edge by a toggle
	always_comb begin
		link_next = link_reg;
		link_next.bit_val = SDA_IN;
		link_next.tog = ~link_reg.tog;
	end

	// clock line is only ever an input here
	always_ff @(posedge SCL_IN or posedge RST_IN) begin
		if (RST_IN) begin
			link_reg <= '0;
		end else begin
			link_reg <= link_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system domain state

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		logic tog_s1;
		logic tog_s2;
		logic tog_s3;
		logic [19:0] strap_s1;
		logic [19:0] strap_s2;
		logic load_done;
		logic [1:0] load_cnt;
		ieq_pkg::ieq_state_t state;
		logic [7:0] shift;
		logic [2:0] bitcnt;
		logic got_byte;
		logic [3:0] ptr;
		logic rw;
		logic filler_done;
		logic ack_ok;
		logic sda_oe;
		logic [7:0] a_ctrl;
		logic [7:0] b_ctrl;
		logic [7:0] test_a;
		logic [7:0] test_b;
	} ieq_sys_t;

	ieq_sys_t s_reg;
	ieq_sys_t s_next;

	// read decode, unmapped offsets read zero
	function automatic logic [7:0] read_byte(input ieq_sys_t s, input logic [3:0] ofs);
		logic [7:0] r;
		r = ieq_pkg::UNMAPPED_READ;
		case (ofs)
			ieq_pkg::OFS_A_SIDE_CTRL: r = s.a_ctrl;
			ieq_pkg::OFS_B_SIDE_CTRL: r = s.b_ctrl;
			ieq_pkg::OFS_MFG_TEST_A: r = s.test_a;
			ieq_pkg::OFS_MFG_TEST_B: r = s.test_b;
			default: r = ieq_pkg::UNMAPPED_READ;
		endcase
		return r;
	endfunction

	// events seen from the synchronised bus lines
	logic rise_ev;
	logic fall_ev;
	logic start_ev;
	logic stop_ev;
	logic addr_hit;
	logic cfg_bus;
	logic [7:0] rd_data;
	logic commit;

	assign rise_ev = s_reg.tog_s2 ^ s_reg.tog_s3;
	assign fall_ev = s_reg.scl_s3 & ~s_reg.scl_s2;
	assign start_ev = s_reg.scl_s2 & s_reg.scl_s3 & s_reg.sda_s3 & ~s_reg.sda_s2;
	assign stop_ev = s_reg.scl_s2 & s_reg.scl_s3 & ~s_reg.sda_s3 & s_reg.sda_s2;
	assign cfg_bus = s_reg.strap_s2[0];
	assign rd_data = read_byte(s_reg, s_reg.ptr);
	assign commit = (s_reg.state == ieq_pkg::IEQ_WR_BYTE) & fall_ev & s_reg.got_byte;

	// address 1 1 a4 0 0 a1 a0 from straps
	assign addr_hit = (s_reg.shift[7:1] ==
		{ieq_pkg::ADDR_FIXED_HI, s_reg.strap_s2[3], ieq_pkg::ADDR_FIXED_MID, s_reg.strap_s2[2:1]});

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_next = s_reg;
		// two-flop synchronisers
		s_next.scl_s1 = SCL_IN;
		s_next.scl_s2 = s_reg.scl_s1;
		s_next.scl_s3 = s_reg.scl_s2;
		s_next.sda_s1 = SDA_IN;
		s_next.sda_s2 = s_reg.sda_s1;
		s_next.sda_s3 = s_reg.sda_s2;
		s_next.tog_s1 = link_reg.tog;
		s_next.tog_s2 = s_reg.tog_s1;
		s_next.tog_s3 = s_reg.tog_s2;
		s_next.strap_s1 = {A_SIDE_EQ_SELECT_IN, A_SIDE_DEEMPH_LEVEL_IN, A_SIDE_SWING_LEVEL_IN,
			B_SIDE_EQ_SELECT_IN, B_SIDE_DEEMPH_LEVEL_IN, B_SIDE_SWING_LEVEL_IN,
			BUS_ADDR_STRAP_BIT4_IN, BUS_ADDR_STRAP_BIT1_IN, BUS_ADDR_STRAP_BIT0_IN, CFG_SRC_BUS_IN};
		s_next.strap_s2 = s_reg.strap_s1;

		// take the straps once, after the synchronisers settle
		if (!s_reg.load_done) begin
			if (s_reg.load_cnt == ieq_pkg::STRAP_SETTLE_CYCLES) begin
				s_next.a_ctrl = s_reg.strap_s2[19:12];
				s_next.b_ctrl = s_reg.strap_s2[11:4];
				s_next.load_done = 1'b1;
			end else begin
				s_next.load_cnt = 2'(s_reg.load_cnt + 2'h1);
			end
		end

		// protocol engine
		case (s_reg.state)
			ieq_pkg::IEQ_IDLE: begin
				s_next.sda_oe = 1'b0;
			end
			ieq_pkg::IEQ_ADDR, ieq_pkg::IEQ_WR_BYTE: begin
				// eight bits in, msb first
				if (rise_ev && !s_reg.got_byte) begin
					s_next.shift = {s_reg.shift[6:0], link_reg.bit_val};
					s_next.bitcnt = 3'(s_reg.bitcnt + 3'h1);
					s_next.got_byte = (s_reg.bitcnt == 3'h7);
				end
				if (fall_ev && s_reg.got_byte) begin
					s_next.got_byte = 1'b0;
					s_next.bitcnt = 3'h0;
					if (s_reg.state == ieq_pkg::IEQ_ADDR) begin
						if (addr_hit) begin
							s_next.rw = s_reg.shift[0];
							s_next.ptr = 4'h0;
							s_next.filler_done = 1'b0;
							s_next.sda_oe = 1'b1;
							s_next.state = ieq_pkg::IEQ_ACK_TX;
						end else begin
							s_next.state = ieq_pkg::IEQ_IDLE;
						end
					end else begin
						// first data byte is filler, later ones land at ptr
						if (!s_reg.filler_done) begin
							s_next.filler_done = 1'b1;
						end else begin
							if (s_reg.load_done) begin
								case (s_reg.ptr)
									ieq_pkg::OFS_A_SIDE_CTRL: if (cfg_bus) s_next.a_ctrl = s_reg.shift;
									ieq_pkg::OFS_B_SIDE_CTRL: if (cfg_bus) s_next.b_ctrl = s_reg.shift;
									ieq_pkg::OFS_MFG_TEST_A: s_next.test_a = s_reg.shift;
									ieq_pkg::OFS_MFG_TEST_B: s_next.test_b = s_reg.shift;
									default: s_next.test_a = s_reg.test_a;
								endcase
							end
							s_next.ptr = 4'(s_reg.ptr + 4'h1);
						end
						s_next.sda_oe = 1'b1;
						s_next.state = ieq_pkg::IEQ_ACK_TX;
					end
				end
			end
			ieq_pkg::IEQ_ACK_TX: begin
				// hold low through the ack high phase; on its fall release for a write, drive read bit 7 for a read
				if (fall_ev) begin
					s_next.bitcnt = 3'h0;
					if (s_reg.rw) begin
						s_next.shift = rd_data;
						s_next.sda_oe = ~rd_data[7];
						s_next.state = ieq_pkg::IEQ_RD_BIT;
					end else begin
						s_next.sda_oe = 1'b0;
						s_next.state = ieq_pkg::IEQ_WR_BYTE;
					end
				end
			end
			ieq_pkg::IEQ_RD_BIT: begin
				// shift out on each falling edge
				if (fall_ev) begin
					if (s_reg.bitcnt == 3'h7) begin
						s_next.sda_oe = 1'b0;
						s_next.ack_ok = 1'b0;
						s_next.ptr = 4'(s_reg.ptr + 4'h1);
						s_next.state = ieq_pkg::IEQ_RD_ACK;
					end else begin
						s_next.bitcnt = 3'(s_reg.bitcnt + 3'h1);
						s_next.shift = {s_reg.shift[6:0], 1'b0};
						s_next.sda_oe = ~s_reg.shift[6];
					end
				end
			end
			ieq_pkg::IEQ_RD_ACK: begin
				// master ack keeps reading, nack ends the read
				if (rise_ev) begin
					s_next.ack_ok = ~link_reg.bit_val;
				end
				if (fall_ev) begin
					s_next.bitcnt = 3'h0;
					if (s_reg.ack_ok) begin
						s_next.shift = rd_data;
						s_next.sda_oe = ~rd_data[7];
						s_next.state = ieq_pkg::IEQ_RD_BIT;
					end else begin
						s_next.state = ieq_pkg::IEQ_IDLE;
					end
				end
			end
			default: begin
				s_next.state = ieq_pkg::IEQ_IDLE;
				s_next.sda_oe = 1'b0;
			end
		endcase

		// start and stop override the engine's state and data drive
		if (start_ev) begin
			s_next.state = ieq_pkg::IEQ_ADDR;
			s_next.bitcnt = 3'h0;
			s_next.got_byte = 1'b0;
			s_next.sda_oe = 1'b0;
		end else if (stop_ev) begin
			s_next.state = ieq_pkg::IEQ_IDLE;
			s_next.sda_oe = 1'b0;
		end
	end

	// system register
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s_reg <= '0;
			s_reg.scl_s1 <= 1'b1;
			s_reg.scl_s2 <= 1'b1;
			s_reg.scl_s3 <= 1'b1;
			s_reg.sda_s1 <= 1'b1;
			s_reg.sda_s2 <= 1'b1;
			s_reg.sda_s3 <= 1'b1;
			s_reg.state <= ieq_pkg::IEQ_IDLE;
			s_reg.test_a <= ieq_pkg::MFG_TEST_A_RST;
			s_reg.test_b <= ieq_pkg::MFG_TEST_B_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs: one byte per side fans out to every channel

	always_comb begin
		for (int i = 0; i < ieq_pkg::CHANNELS_PER_SIDE; i++) begin
			A_SIDE_EQ_SELECT_OUT[i] = s_reg.a_ctrl[ieq_pkg::EQ_SEL_MSB:ieq_pkg::EQ_SEL_LSB];
			A_SIDE_DEEMPH_LEVEL_OUT[i] = s_reg.a_ctrl[ieq_pkg::DEEMPH_MSB:ieq_pkg::DEEMPH_LSB];
			A_SIDE_SWING_LEVEL_OUT[i] = s_reg.a_ctrl[ieq_pkg::SWING_MSB:ieq_pkg::SWING_LSB];
			B_SIDE_EQ_SELECT_OUT[i] = s_reg.b_ctrl[ieq_pkg::EQ_SEL_MSB:ieq_pkg::EQ_SEL_LSB];
			B_SIDE_DEEMPH_LEVEL_OUT[i] = s_reg.b_ctrl[ieq_pkg::DEEMPH_MSB:ieq_pkg::DEEMPH_LSB];
			B_SIDE_SWING_LEVEL_OUT[i] = s_reg.b_ctrl[ieq_pkg::SWING_MSB:ieq_pkg::SWING_LSB];
		end
	end

	// data line only ever pulled low
	assign SDA_OUT = 1'b0;
	assign SDA_OE_OUT = s_reg.sda_oe;
	assign MFG_TEST_A_OUT = s_reg.test_a;
	assign MFG_TEST_B_OUT = s_reg.test_b;
	assign CFG_LOADED_OUT = s_reg.load_done;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);

	strap_load_a: assert property ((!s_reg.load_done && s_reg.load_cnt == ieq_pkg::STRAP_SETTLE_CYCLES)
		|=> (s_reg.a_ctrl == $past(s_reg.strap_s2[19:12])) && (s_reg.b_ctrl == $past(s_reg.strap_s2[11:4])))
		else $error("control bytes not loaded from straps");
	strap_lock_a: assert property ((s_reg.load_done && !cfg_bus)
		|=> $stable(s_reg.a_ctrl) && $stable(s_reg.b_ctrl))
		else $error("control byte changed in strap mode");
	fanout_same_a: assert property (A_SIDE_EQ_SELECT_OUT[3] == s_reg.a_ctrl[7:5]
		&& B_SIDE_SWING_LEVEL_OUT[0] == s_reg.b_ctrl[1:0])
		else $error("channel settings differ from control byte");
	test_reset_a: assert property (!s_reg.load_done |-> s_reg.test_a == 8'h00 && s_reg.test_b == 8'hef)
		else $error("test bytes not at power-up values");
	addr_ack_a: assert property ((s_reg.state == ieq_pkg::IEQ_ADDR && fall_ev && s_reg.got_byte && addr_hit
		&& !start_ev && !stop_ev)
		|=> s_reg.sda_oe && s_reg.ptr == 4'h0 && s_reg.state == ieq_pkg::IEQ_ACK_TX)
		else $error("matched address not acknowledged from offset zero");
	addr_miss_a: assert property ((s_reg.state == ieq_pkg::IEQ_ADDR && fall_ev && s_reg.got_byte && !addr_hit)
		|=> !s_reg.sda_oe && s_reg.state != ieq_pkg::IEQ_ACK_TX)
		else $error("foreign address acknowledged");
	ack_hold_a: assert property ((s_reg.state == ieq_pkg::IEQ_ACK_TX && !fall_ev && !start_ev && !stop_ev)
		|=> s_reg.sda_oe)
		else $error("acknowledge released early");
	filler_skip_a: assert property ((commit && !s_reg.filler_done && !start_ev && !stop_ev)
		|=> s_reg.filler_done && $stable(s_reg.ptr) && $stable(s_reg.test_a) && $stable(s_reg.test_b))
		else $error("filler byte was stored");
	ptr_step_a: assert property ((commit && s_reg.filler_done) |=> s_reg.ptr == 4'($past(s_reg.ptr) + 4'h1))
		else $error("byte pointer did not advance");
	msb_first_a: assert property ((s_reg.state == ieq_pkg::IEQ_ACK_TX && fall_ev && s_reg.rw
		&& !start_ev && !stop_ev)
		|=> s_reg.sda_oe == ~$past(rd_data[7]))
		else $error("read byte not sent msb first");
	start_seen_a: assert property (start_ev |=> s_reg.state == ieq_pkg::IEQ_ADDR && !s_reg.sda_oe)
		else $error("start not recognised");
	stop_seen_a: assert property (stop_ev && !start_ev |=> s_reg.state == ieq_pkg::IEQ_IDLE && !s_reg.sda_oe)
		else $error("stop not recognised");

	// acknowledge release, read shifting, read end and stores
	ack_release_a: assert property ((s_reg.state == ieq_pkg::IEQ_ACK_TX && fall_ev && !s_reg.rw)
		|=> !s_reg.sda_oe)
		else $error("write acknowledge not released");
	read_shift_a: assert property ((s_reg.state == ieq_pkg::IEQ_RD_BIT && fall_ev && s_reg.bitcnt != 3'h7
		&& !start_ev && !stop_ev)
		|=> s_reg.sda_oe == ~$past(s_reg.shift[6]))
		else $error("read bit out of order");
	read_release_a: assert property ((s_reg.state == ieq_pkg::IEQ_RD_BIT && fall_ev && s_reg.bitcnt == 3'h7)
		|=> !s_reg.sda_oe && s_reg.ptr == 4'($past(s_reg.ptr) + 4'h1))
		else $error("data line held after eighth read bit");
	nack_idle_a: assert property ((s_reg.state == ieq_pkg::IEQ_RD_ACK && fall_ev && !s_reg.ack_ok && !start_ev)
		|=> s_reg.state == ieq_pkg::IEQ_IDLE && !s_reg.sda_oe)
		else $error("read not ended after master nack");
	idle_quiet_a: assert property (s_reg.state == ieq_pkg::IEQ_IDLE |-> !s_reg.sda_oe)
		else $error("data line pulled while idle");
	ctrl_store_a: assert property ((commit && s_reg.filler_done && s_reg.load_done && cfg_bus
		&& s_reg.ptr == ieq_pkg::OFS_B_SIDE_CTRL)
		|=> s_reg.b_ctrl == $past(s_reg.shift))
		else $error("b-side control byte not written");
	test_store_a: assert property ((commit && s_reg.filler_done && s_reg.load_done
		&& s_reg.ptr == ieq_pkg::OFS_MFG_TEST_B)
		|=> s_reg.test_b == $past(s_reg.shift))
		else $error("test byte eleven not written");

	write_seen_c: cover property (commit && s_reg.filler_done && cfg_bus && s_reg.ptr == ieq_pkg::OFS_B_SIDE_CTRL);
	read_seen_c: cover property (s_reg.state == ieq_pkg::IEQ_RD_ACK && fall_ev && s_reg.ack_ok);
	strap_write_c: cover property (commit && s_reg.filler_done && !cfg_bus && s_reg.ptr == ieq_pkg::OFS_A_SIDE_CTRL);
	nack_end_c: cover property (s_reg.state == ieq_pkg::IEQ_RD_ACK && fall_ev && !s_reg.ack_ok);

endmodule

// file: sim/ieq_i2c_master.sv
// i2c bus master model driving the config port's two-wire bus
// assumes the bench resolves the data wire with a pull-up and feeds it back
module ieq_i2c_master (
	input wire logic clk_in, // paces every bus phase
	input wire logic sda_in, // resolved data line level
	output logic scl_out, // bus clock, held high between frames
	output logic sda_low_out // high while pulling data low
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus idles released
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one quarter of a bit, 500 ns, keeps setup and hold wide
	task automatic q();
		repeat (10) @(posedge clk_in);
	endtask

	// start or repeated start: data falls while clock high
	task automatic start();
		q();
		sda_low_out <= 1'b0;
		q();
		scl_out <= 1'b1;
		q();
		sda_low_out <= 1'b1;
		q();
		scl_out <= 1'b0;
	endtask

	// stop: data rises while clock high
	task automatic stop();
		q();
		sda_low_out <= 1'b1;
		q();
		scl_out <= 1'b1;
		q();
		sda_low_out <= 1'b0;
		q();
	endtask

	// one bit; data set in clock low, sampled early and late in clock high
	task automatic bit_io(input logic b, output logic r);
		q();
		sda_low_out <= !b;
		q();
		scl_out <= 1'b1;
		q();
		r = sda_in;
		q();
		r = r | sda_in; // low only if low at both samples of the high phase
		scl_out <= 1'b0;
	endtask

	// eight bits msb first, then the acknowledge clock
	task automatic xfer(input logic [7:0] tx, input logic ack_val, output logic [7:0] rx, output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_val, nak);
	endtask
endmodule

// file: sim/tb_ieq_config_slave.sv
// self-checking bench for the equalizer config port
// assumes the design package and the i2c master model are compiled first
module tb_ieq_config_slave;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_in = 1'b0;
	logic rst_in;
	logic cfg_bus = 1'b1;
	logic [7:0] a_strap = 8'hce;
	logic [7:0] b_strap = 8'h31;
	logic [2:0] adr_strap = 3'b101; // bit4, bit1, bit0
	logic scl;
	logic m_low;
	logic sda_drv;
	logic sda_oe;
	logic loaded;
	logic [3:0][2:0] a_eq, a_de, b_eq, b_de;
	logic [3:0][1:0] a_sw, b_sw;
	logic [7:0] tst_a, tst_b;
	wire sda_line;
	int bad_count = 0;
	int total_checks = 0;

	// 20 MHz system clock
	always #25 clk_in = !clk_in;

	// open-drain data wire with pull-up
	assign sda_line = !(m_low || (sda_oe && !sda_drv));

	////////////////////////////////////////////////////////////////////////////////
	ieq_config_slave ieq_config_slave_inst (
		.CLK_IN(clk_in), .RST_IN(rst_in), .SCL_IN(scl), .SDA_IN(sda_line),
		.SDA_OUT(sda_drv), .SDA_OE_OUT(sda_oe),
		.A_SIDE_EQ_SELECT_IN(a_strap[7:5]), .A_SIDE_DEEMPH_LEVEL_IN(a_strap[4:2]),
		.A_SIDE_SWING_LEVEL_IN(a_strap[1:0]), .B_SIDE_EQ_SELECT_IN(b_strap[7:5]),
		.B_SIDE_DEEMPH_LEVEL_IN(b_strap[4:2]), .B_SIDE_SWING_LEVEL_IN(b_strap[1:0]),
		.BUS_ADDR_STRAP_BIT0_IN(adr_strap[0]), .BUS_ADDR_STRAP_BIT1_IN(adr_strap[1]),
		.BUS_ADDR_STRAP_BIT4_IN(adr_strap[2]), .CFG_SRC_BUS_IN(cfg_bus),
		.A_SIDE_EQ_SELECT_OUT(a_eq), .A_SIDE_DEEMPH_LEVEL_OUT(a_de), .A_SIDE_SWING_LEVEL_OUT(a_sw),
		.B_SIDE_EQ_SELECT_OUT(b_eq), .B_SIDE_DEEMPH_LEVEL_OUT(b_de), .B_SIDE_SWING_LEVEL_OUT(b_sw),
		.MFG_TEST_A_OUT(tst_a), .MFG_TEST_B_OUT(tst_b), .CFG_LOADED_OUT(loaded)
	);

	ieq_i2c_master ieq_i2c_master_inst (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_low_out(m_low));

	////////////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// every channel of both sides against its control byte
	task automatic chk_ctrl(input logic [7:0] ea, input logic [7:0] eb);
		for (int i = 0; i < 4; i++) begin
			check({a_eq[i], a_de[i], a_sw[i]}, ea);
			check({b_eq[i], b_de[i], b_sw[i]}, eb);
		end
	endtask

	// read offsets 0..11; hi holds the expected bytes 8..11
	task automatic rd_map(input logic [6:0] adr, input logic [31:0] hi);
		logic [7:0] rx;
		logic nak;
		ieq_i2c_master_inst.start();
		ieq_i2c_master_inst.xfer({adr, 1'b1}, 1'b1, rx, nak);
		check({7'h00, nak}, 8'h00);
		for (int i = 0; i < 12; i++) begin
			ieq_i2c_master_inst.xfer(8'hff, i == 11, rx, nak);
			check(rx, (i < 8) ? 8'h00 : hi[8 * (11 - i) +: 8]);
		end
		ieq_i2c_master_inst.stop();
	endtask

	// filler, then all ones to 0..7, then hi to bytes 8..11; n counts data bytes
	task automatic wr_map(input logic [6:0] adr, input logic [31:0] hi, input int n, input logic exp_nak);
		logic [7:0] rx;
		logic nak;
		ieq_i2c_master_inst.start();
		ieq_i2c_master_inst.xfer({adr, 1'b0}, 1'b1, rx, nak);
		check({7'h00, nak}, {7'h00, exp_nak});
		for (int k = 0; k < n; k++) begin
			ieq_i2c_master_inst.xfer((k == 0) ? 8'h77 : (k < 9) ? 8'hff : hi[8 * (12 - k) +: 8], 1'b1, rx, nak);
			check({7'h00, nak}, 8'h00);
		end
		ieq_i2c_master_inst.stop();
	endtask

	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		// a time-zero reset edge also clears the bus-clock flops
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		check(tst_a, 8'h00);
		check(tst_b, 8'hef);
		rst_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		check({7'h00, loaded}, 8'h01);
		chk_ctrl(8'hce, 8'h31);
		rd_map(7'h71, 32'hce31_00ef);
		$display("test strap load done");
		wr_map(7'h71, 32'ha53c_5a96, 13, 1'b0);
		repeat (4) @(posedge clk_in);
		chk_ctrl(8'ha5, 8'h3c);
		check(tst_a, 8'h5a);
		check(tst_b, 8'h96);
		rd_map(7'h71, 32'ha53c_5a96);
		$display("test bus write done");
		cfg_bus <= 1'b0;
		wr_map(7'h71, 32'h1122_00ef, 13, 1'b0);
		repeat (4) @(posedge clk_in);
		chk_ctrl(8'ha5, 8'h3c);
		check(tst_a, 8'h00);
		check(tst_b, 8'hef);
		$display("test strap mode done");
		adr_strap <= 3'b111;
		wr_map(7'h71, 32'h0000_0000, 0, 1'b1);
		wr_map(7'h79, 32'h0000_0000, 0, 1'b1);
		rd_map(7'h73, 32'ha53c_00ef);
		$display("test address done");
		end_of_test();
	end

	// watchdog, about twice the expected run
	initial begin
		repeat (50000) @(posedge clk_in);
		bad_count++;
		$display("ERROR %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule
